// ===== rtl/doorbell_defines.svh
`ifndef DOORBELL_DEFINES_SVH
`define DOORBELL_DEFINES_SVH

// register byte offsets
`define DB_CLEAR_OFFSET       8'h70
`define DB_RAISE_OFFSET       8'h74
`define DB_CLR_PERM_OFFSET    8'h78
`define DB_SET_PERM_OFFSET    8'h7c
`define DB_IRQ_STATUS_OFFSET  8'h80
`define DB_IRQ_MASK_OFFSET    8'h84
// field positions
`define DB_PRI_LSB            0
`define DB_SEC_LSB            16
// reset values
`define DB_REQ_RESET          16'h0000
`define DB_PERM_RESET         16'hffff
`define DB_IRQ_RESET          2'h0
// axi responses
`define DB_RESP_OKAY          2'h0
`define DB_RESP_SLVERR        2'h2

`endif

// ===== rtl/doorbell_pkg.sv
package doorbell_pkg;

  // one side's request and permission bits
  typedef struct packed {
    logic [15:0] req;
    logic [15:0] clr_perm;
    logic [15:0] set_perm;
  } side_s;

  // captured write
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_s;

endpackage : doorbell_pkg

// ===== rtl/doorbell_irq.sv
// Behaviour
// - A one written to a low half-word bit of the raise register sets that primary request; reset zero.
// - A one written to an upper half-word bit of the raise register sets that secondary request; reset zero.
// - Reading the primary raise field returns the live primary request bits.
// - Reading the secondary raise field returns the live secondary request bits.
// - A one written to a low bit of the clear-permission register clears that primary mask bit.
// - A one written to an upper bit of the clear-permission register clears that secondary mask bit.
// - A primary clear-permission bit at one blocks clearing its request; resets to all ones.
// - A secondary clear-permission bit at one blocks clearing its request; resets to all ones.
// - A one written to a low bit of the set-permission register sets that primary mask bit.
// - A one written to an upper bit of the set-permission register sets that secondary mask bit.
// - A primary set-permission bit at one blocks setting its request; resets to all ones.
// - A secondary set-permission bit at one blocks setting its request; resets to all ones.
// - Reads of both permission registers return the present mask bits.
// - A one written to the request-clear register clears the request, subject to clear permission.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "doorbell_defines.svh"

module doorbell_irq
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output var  logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output var  logic        S_AXI_WREADY_OUT,
  output var  logic [1:0]  S_AXI_BRESP_OUT,
  output var  logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output var  logic        S_AXI_ARREADY_OUT,
  output var  logic [31:0] S_AXI_RDATA_OUT,
  output var  logic [1:0]  S_AXI_RRESP_OUT,
  output var  logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  output var  logic        PRI_IRQ_OUT,
  output var  logic        SEC_IRQ_OUT,
  output var  logic        IRQ_OUT
);

  logic                 rst_meta;
  logic                 rst_n;
  logic                 aw_held;
  logic                 w_held;
  doorbell_pkg::wr_s    wr;
  logic                 wr_fire;
  logic [31:0]          wmask;
  logic [31:0]          clr_bits;
  logic [31:0]          raise_bits;
  doorbell_pkg::side_s  pri;
  doorbell_pkg::side_s  sec;
  logic [1:0]           irq_status;
  logic [1:0]           irq_mask;
  logic [1:0]           req_rise;
  logic [1:0]           req_seen;
  logic [31:0]          wr_ones;
  logic                 hit_clear;
  logic                 hit_raise;
  logic                 hit_clr_perm;
  logic                 hit_set_perm;
  logic                 hit_status;
  logic                 hit_mask;
  logic [15:0]          pri_clr_go;
  logic [15:0]          sec_clr_go;
  logic [15:0]          pri_set_go;
  logic [15:0]          sec_set_go;
  logic [31:0]          next_rdata;
  logic                 rd_ok;
  logic                 wr_ok;

  // reset release synchroniser
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // write address / data capture, either order
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      wr                <= '0;
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT  <= 1'b1;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        wr.addr           <= S_AXI_AWADDR_IN;
        aw_held           <= 1'b1;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        wr.data          <= S_AXI_WDATA_IN;
        wr.strb          <= S_AXI_WSTRB_IN;
        w_held           <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
      begin
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT  <= 1'b1;
      end
    end
  end

  // a write executes once both halves are held and no response is pending
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID_OUT;

  // byte strobes expanded to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_strb
      assign wmask[gi*8 +: 8] = {8{wr.strb[gi]}};
    end
  endgenerate

  // written ones, masked by the byte strobes
  assign wr_ones = wr.data & wmask;

  // write-one strobes for the request registers, only on the cycle a write executes
  assign clr_bits   = (wr_fire && hit_clear) ? wr_ones : 32'h0;
  assign raise_bits = (wr_fire && hit_raise) ? wr_ones : 32'h0;

  // per-side strobes that survive the permission masks
  // a permission bit at one swallows its strobe, so a doorbell that
  // one side has locked cannot be disturbed by the other
  assign pri_clr_go = clr_bits[`DB_PRI_LSB +: 16] & ~pri.clr_perm;
  assign sec_clr_go = clr_bits[`DB_SEC_LSB +: 16] & ~sec.clr_perm;
  assign pri_set_go = raise_bits[`DB_PRI_LSB +: 16] & ~pri.set_perm;
  assign sec_set_go = raise_bits[`DB_SEC_LSB +: 16] & ~sec.set_perm;

  // primary side: requests and both permission masks; the set-permission bits
  // only ever gain ones, here and in the secondary block, so from reset no
  // doorbell ever rises, as no logic lowers them
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri.req      <= `DB_REQ_RESET;
      pri.clr_perm <= `DB_PERM_RESET;
      pri.set_perm <= `DB_PERM_RESET;
    end
    else
    begin
      // set wins over clear, though one write never carries both
      pri.req <= (pri.req & ~pri_clr_go) | pri_set_go;
      if (wr_fire && hit_clr_perm)
      begin
        pri.clr_perm <= pri.clr_perm & ~wr_ones[`DB_PRI_LSB +: 16];
      end
      if (wr_fire && hit_set_perm)
      begin
        pri.set_perm <= pri.set_perm | wr_ones[`DB_PRI_LSB +: 16];
      end
    end
  end

  // secondary side: requests and both permission masks
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec.req      <= `DB_REQ_RESET;
      sec.clr_perm <= `DB_PERM_RESET;
      sec.set_perm <= `DB_PERM_RESET;
    end
    else
    begin
      // set wins over clear, though one write never carries both
      sec.req <= (sec.req & ~sec_clr_go) | sec_set_go;
      if (wr_fire && hit_clr_perm)
      begin
        sec.clr_perm <= sec.clr_perm & ~wr_ones[`DB_SEC_LSB +: 16];
      end
      if (wr_fire && hit_set_perm)
      begin
        sec.set_perm <= sec.set_perm | wr_ones[`DB_SEC_LSB +: 16];
      end
    end
  end

  // rising edge of each side's request activity; bit 0 primary, bit 1 secondary
  assign req_rise = {|sec.req, |pri.req} & ~req_seen;

  // last cycle's activity; reset equals the idle level, so no false edge after reset
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_seen <= `DB_IRQ_RESET;
    end
    else
    begin
      req_seen <= {|sec.req, |pri.req};
    end
  end

  // sticky event status, write one to clear; an edge in the clear cycle wins
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status <= `DB_IRQ_RESET;
    end
    else if (wr_fire && hit_status && wr.strb[0])
    begin
      irq_status <= (irq_status & ~wr.data[1:0]) | req_rise;
    end
    else
    begin
      irq_status <= irq_status | req_rise;
    end
  end

  // event enables, plain read-write
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_mask <= `DB_IRQ_RESET;
    end
    else if (wr_fire && hit_mask && wr.strb[0])
    begin
      irq_mask <= wr.data[1:0];
    end
  end

  // doorbell line toward the primary side, registered
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PRI_IRQ_OUT <= 1'b0;
    end
    else
    begin
      PRI_IRQ_OUT <= |pri.req;
    end
  end

  // doorbell line toward the secondary side, registered
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SEC_IRQ_OUT <= 1'b0;
    end
    else
    begin
      SEC_IRQ_OUT <= |sec.req;
    end
  end

  // summary line for unmasked sticky events, registered
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      IRQ_OUT <= |(irq_status & irq_mask);
    end
  end

  // write address decode: one hit per register, unmapped answers an error
  always_comb
  begin
    hit_clear    = 1'b0;
    hit_raise    = 1'b0;
    hit_clr_perm = 1'b0;
    hit_set_perm = 1'b0;
    hit_status   = 1'b0;
    hit_mask     = 1'b0;
    wr_ok        = 1'b1;
    unique case (wr.addr)
      `DB_CLEAR_OFFSET:
        hit_clear = 1'b1;
      `DB_RAISE_OFFSET:
        hit_raise = 1'b1;
      `DB_CLR_PERM_OFFSET:
        hit_clr_perm = 1'b1;
      `DB_SET_PERM_OFFSET:
        hit_set_perm = 1'b1;
      `DB_IRQ_STATUS_OFFSET:
        hit_status = 1'b1;
      `DB_IRQ_MASK_OFFSET:
        hit_mask = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= `DB_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT  <= wr_ok ? `DB_RESP_OKAY : `DB_RESP_SLVERR;
    end
    else if (S_AXI_BREADY_IN)
      S_AXI_BVALID_OUT <= 1'b0;
  end

  // read data mux
  always_comb
  begin
    next_rdata = 32'h0;
    rd_ok      = 1'b1;
    unique case (S_AXI_ARADDR_IN)
      `DB_CLEAR_OFFSET, `DB_RAISE_OFFSET:
        next_rdata = {sec.req, pri.req};
      `DB_CLR_PERM_OFFSET:
        next_rdata = {sec.clr_perm, pri.clr_perm};
      `DB_SET_PERM_OFFSET:
        next_rdata = {sec.set_perm, pri.set_perm};
      `DB_IRQ_STATUS_OFFSET:
        next_rdata = {30'h0, irq_status};
      `DB_IRQ_MASK_OFFSET:
        next_rdata = {30'h0, irq_mask};
      default:
        rd_ok = 1'b0;
    endcase
  end

  // read channel: accept, answer next cycle, hold until taken
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h0;
      S_AXI_RRESP_OUT   <= `DB_RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
    begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b1;
      S_AXI_RDATA_OUT   <= next_rdata;
      S_AXI_RRESP_OUT   <= rd_ok ? `DB_RESP_OKAY : `DB_RESP_SLVERR;
    end
    else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
    begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT  <= 1'b0;
    end
  end

endmodule : doorbell_irq

`default_nettype wire

// ===== test/doorbell_host.sv
`timescale 1ns/100ps
`default_nettype none
// host model: one axi4-lite write and one read at a time
module doorbell_host
(
  input  wire logic        clk_in,
  input  wire logic        awready_in,
  input  wire logic        wready_in,
  input  wire logic        bvalid_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        arready_in,
  input  wire logic        rvalid_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic [31:0] rdata_in,
  output var  logic [7:0]  awaddr_out,
  output var  logic        awvalid_out,
  output var  logic [31:0] wdata_out,
  output var  logic [3:0]  wstrb_out,
  output var  logic        wvalid_out,
  output var  logic        bready_out,
  output var  logic [7:0]  araddr_out,
  output var  logic        arvalid_out,
  output var  logic        rready_out,
  output var  logic        hung_out
);
  // bus idle at time zero
  initial
  begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out, hung_out} = '0;
  end
  // each channel holds until its own ready, bready until bvalid
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
    int n;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= s;
    {awvalid_out, wvalid_out, bready_out} <= 3'h7;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_in);
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
      if (bvalid_in) break;
    end
    r = bresp_in;
    bready_out <= 1'b0;
    if (n == 40) hung_out <= 1'b1;
  endtask : write
  // rready held until rvalid is seen
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_in);
    araddr_out <= a;
    {arvalid_out, rready_out} <= 2'h3;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_in);
      if (arready_in) arvalid_out <= 1'b0;
      if (rvalid_in) break;
    end
    {d, r} = {rdata_in, rresp_in};
    rready_out <= 1'b0;
    if (n == 40) hung_out <= 1'b1;
  endtask : read
endmodule : doorbell_host
`default_nettype wire

// ===== test/doorbell_irq_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "doorbell_defines.svh"
// bus answers and irq lines at the top ports
module doorbell_irq_sva
(
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [7:0]  S_AXI_AWADDR_IN,
  input wire logic        S_AXI_AWVALID_IN,
  input wire logic        S_AXI_AWREADY_OUT,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic [7:0]  S_AXI_ARADDR_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic [1:0]  S_AXI_RRESP_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        PRI_IRQ_OUT,
  input wire logic        SEC_IRQ_OUT,
  input wire logic        IRQ_OUT
);
  logic [7:0] waddr;
  logic [7:0] raddr;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // offsets that answer okay
  function automatic logic hit(input logic [7:0] a);
    return a inside {`DB_CLEAR_OFFSET, `DB_RAISE_OFFSET, `DB_CLR_PERM_OFFSET,
      `DB_SET_PERM_OFFSET, `DB_IRQ_STATUS_OFFSET, `DB_IRQ_MASK_OFFSET};
  endfunction : hit
  // addresses of the transfers in flight
  always_ff @(posedge CLK_IN)
  begin
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) waddr <= S_AXI_AWADDR_IN;
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) raddr <= S_AXI_ARADDR_IN;
  end
  sequence aw_take;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
  endsequence
  sequence r_new;
    $rose(S_AXI_RVALID_OUT);
  endsequence
  wr_answer_a: assert property (aw_take |-> ##[1:3] S_AXI_BVALID_OUT)
    else $error("write answer late");
  rd_answer_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
  rd_busy_a: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read address taken while busy");
  wr_resp_a: assert property ($rose(S_AXI_BVALID_OUT) |->
    S_AXI_BRESP_OUT == (hit(waddr) ? `DB_RESP_OKAY : `DB_RESP_SLVERR))
    else $error("write response code wrong");
  rd_resp_a: assert property (r_new |-> S_AXI_RRESP_OUT ==
    (hit(raddr) ? `DB_RESP_OKAY : `DB_RESP_SLVERR) && (hit(raddr) || S_AXI_RDATA_OUT == 32'h0))
    else $error("read response code wrong");
  pri_irq_a: assert property (
    r_new ##0 raddr == `DB_RAISE_OFFSET |-> PRI_IRQ_OUT == |S_AXI_RDATA_OUT[15:0])
    else $error("primary irq differs from requests");
  sec_irq_a: assert property (
    r_new ##0 raddr == `DB_RAISE_OFFSET |-> SEC_IRQ_OUT == |S_AXI_RDATA_OUT[31:16])
    else $error("secondary irq differs from requests");
  irq_idle_a: assert property (!PRI_IRQ_OUT && !SEC_IRQ_OUT && !IRQ_OUT)
    else $error("irq raised while raising is blocked");
endmodule : doorbell_irq_sva
bind doorbell_irq doorbell_irq_sva doorbell_irq_sva_i (.CLK_IN, .RST_N_IN, .S_AXI_AWADDR_IN,
  .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT, .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_ARADDR_IN,
  .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT,
  .S_AXI_RVALID_OUT, .PRI_IRQ_OUT, .SEC_IRQ_OUT, .IRQ_OUT);
`default_nettype wire

// ===== test/test_doorbell_irq.sv
`timescale 1ns/100ps
`default_nettype none
`include "doorbell_defines.svh"
module test_doorbell_irq;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [1:0]       resp;
  logic [31:0]      data;
  int               err_count = 0;
  int               n_tests = 0;
  wire logic [7:0]  awaddr, araddr;
  wire logic [31:0] wdata, rdata;
  wire logic [1:0]  bresp, rresp;
  wire logic [3:0]  wstrb;
  wire logic        awvalid, awready, wvalid, wready, bvalid, bready;
  wire logic        arvalid, arready, rvalid, rready, pri, sec, irq, hung;
  // 250 mhz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  doorbell_irq doorbell_irq_i
  (
    .CLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .PRI_IRQ_OUT(pri), .SEC_IRQ_OUT(sec), .IRQ_OUT(irq)
  );
  doorbell_host doorbell_host_i
  (
    .clk_in(clk), .awready_in(awready), .wready_in(wready), .bvalid_in(bvalid),
    .bresp_in(bresp), .arready_in(arready), .rvalid_in(rvalid), .rresp_in(rresp),
    .rdata_in(rdata), .awaddr_out(awaddr), .awvalid_out(awvalid), .wdata_out(wdata),
    .wstrb_out(wstrb), .wvalid_out(wvalid), .bready_out(bready), .araddr_out(araddr),
    .arvalid_out(arvalid),
    .rready_out(rready), .hung_out(hung)
  );
  // a stuck handshake ends the run
  always @(posedge hung)
  begin
    err_count++;
    report_and_stop();
  end
  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    doorbell_host_i.write(a, d, 4'hf, resp);
    chk("write response", {r, 32'h0}, {resp, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    doorbell_host_i.read(a, data, resp);
    chk("read response and data", {r, e}, {resp, data});
  endtask : rd
  task automatic do_reset(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic t_reset_values;
    rd(`DB_RAISE_OFFSET, 32'h0, `DB_RESP_OKAY);
    rd(`DB_CLR_PERM_OFFSET, 32'hffffffff, `DB_RESP_OKAY);
    rd(`DB_SET_PERM_OFFSET, 32'hffffffff, `DB_RESP_OKAY);
    $display("test reset_values done");
  endtask : t_reset_values
  // raising, clearing and zero writes all refused while masks are ones
  task automatic t_blocked;
    wr(`DB_RAISE_OFFSET, 32'hffffffff, `DB_RESP_OKAY);
    rd(`DB_CLEAR_OFFSET, 32'h0, `DB_RESP_OKAY);
    wr(`DB_SET_PERM_OFFSET, 32'h0, `DB_RESP_OKAY);
    rd(`DB_SET_PERM_OFFSET, 32'hffffffff, `DB_RESP_OKAY);
    wr(`DB_CLEAR_OFFSET, 32'hffffffff, `DB_RESP_OKAY);
    chk("irq lines", 34'h0, {32'h0, pri, sec});
    $display("test blocked done");
  endtask : t_blocked
  // clear-permission bits at the half-word boundary
  task automatic t_clear_perm;
    wr(`DB_CLR_PERM_OFFSET, 32'h00018000, `DB_RESP_OKAY);
    rd(`DB_CLR_PERM_OFFSET, 32'hfffe7fff, `DB_RESP_OKAY);
    wr(`DB_CLR_PERM_OFFSET, 32'h0, `DB_RESP_OKAY);
    rd(`DB_CLR_PERM_OFFSET, 32'hfffe7fff, `DB_RESP_OKAY);
    // only byte 2 is strobed: the ones in bytes 0, 1 and 3 must be ignored
    doorbell_host_i.write(`DB_CLR_PERM_OFFSET, 32'h0f0f0f0f, 4'h4, resp);
    chk("strobed write response", {`DB_RESP_OKAY, 32'h0}, {resp, 32'h0});
    rd(`DB_CLR_PERM_OFFSET, 32'hfff07fff, `DB_RESP_OKAY);
    wr(`DB_RAISE_OFFSET, 32'h00018000, `DB_RESP_OKAY);
    rd(`DB_RAISE_OFFSET, 32'h0, `DB_RESP_OKAY);
    $display("test clear_perm done");
  endtask : t_clear_perm
  // unmapped place, interrupt mask and status
  task automatic t_unmapped;
    wr(8'h90, 32'hffffffff, `DB_RESP_SLVERR);
    rd(8'h90, 32'h0, `DB_RESP_SLVERR);
    rd(`DB_CLR_PERM_OFFSET, 32'hfff07fff, `DB_RESP_OKAY);
    wr(`DB_IRQ_MASK_OFFSET, 32'h3, `DB_RESP_OKAY);
    rd(`DB_IRQ_MASK_OFFSET, 32'h3, `DB_RESP_OKAY);
    wr(`DB_IRQ_STATUS_OFFSET, 32'h3, `DB_RESP_OKAY);
    rd(`DB_IRQ_STATUS_OFFSET, 32'h0, `DB_RESP_OKAY);
    chk("irq out", 34'h0, {33'h0, irq});
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic t_second_reset;
    do_reset(2);
    rd(`DB_CLR_PERM_OFFSET, 32'hffffffff, `DB_RESP_OKAY);
    rd(`DB_IRQ_MASK_OFFSET, 32'h0, `DB_RESP_OKAY);
    $display("test second_reset done");
  endtask : t_second_reset
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    do_reset(12);
    t_reset_values();
    t_blocked();
    t_clear_perm();
    t_unmapped();
    t_second_reset();
    report_and_stop();
  end
endmodule : test_doorbell_irq
`default_nettype wire
